// ### logic/rst_stop_ctrl.sv
// Reset source gathering, reset pin indicator and stop/halt sequencing.
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rst_stop_ctrl #(
    parameter int stop_hold_long = rst_stop_pkg::stop_hold_xtal
) (
    // Clock and reset.
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write.
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read.
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Reset pin, open drain.
    input  wire logic        reset_pin_in,
    output logic             reset_pin_out,
    output logic             reset_pin_oe,
    // Reset sources and stop-mode inputs.
    input  wire logic        power_on_event,
    input  wire logic        watchdog_timeout,
    input  wire logic        brownout_warning,
    input  wire logic        stop_exit_request,
    input  wire logic        prec_osc_tick,
    input  wire logic        brownout_stop_option,
    // Outputs to the rest of the chip.
    output logic             system_reset,
    output logic             debug_keep,
    output logic             cpu_reset,
    output logic [15:0]      vector_fetch_addr,
    output logic             cpu_clock_en,
    output logic             sys_clock_en,
    output logic             prec_osc_enable,
    output logic             xtal_enable,
    output logic [1:0]       osc_select,
    output logic             xtal_pins_to_port,
    output logic [7:0]       periph_enable,
    output logic             watchdog_osc_run,
    output logic             watchdog_run,
    output logic             brownout_run,
    output logic             amp_run,
    output logic             stop_recovery_reset
);
    logic [7:0]  ctrl;
    logic [4:0]  cause;
    logic [10:0] power;
    logic [2:0]  pin_sync;
    logic        pin_low;
    logic [2:0]  pin_cnt;
    logic        pin_reset;
    logic [15:0] rst_cnt;
    logic        in_reset;
    logic [12:0] hold_cnt;
    rst_stop_pkg::power_state_t state;
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        do_write;
    logic        internal_event;
    logic        debug_req;
    logic        hold_done;
    logic [3:0]  own_hist;
    logic        own_drive;

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_sync <= 3'h7;
        end else begin
            pin_sync <= {pin_sync[1:0], reset_pin_in};
        end
    end

    // own drive mask
    // Our own drive reaches the filter through the synchroniser, so it is masked that much longer.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            own_hist <= 4'hf;
        end else begin
            own_hist <= {own_hist[2:0], reset_pin_oe};
        end
    end
    assign own_drive = reset_pin_oe || (own_hist != 4'h0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_low <= 1'b0;
            pin_cnt <= 3'h0;
        end else begin
            if (pin_sync[1] == pin_sync[2]) begin
                pin_low <= !pin_sync[2];
            end
            if (!pin_low || own_drive) begin
                pin_cnt <= 3'h0;
            end else if (pin_cnt != rst_stop_pkg::pin_filter) begin
                pin_cnt <= pin_cnt + 3'h1;
            end
        end
    end
    // Our own drive is excluded so the indicator does not latch itself.
    assign pin_reset = pin_low && !own_drive
                       && (pin_cnt >= rst_stop_pkg::pin_filter - 3'h1);

    ////////////////////////////////////////////////////////////////////////
    assign debug_req = ctrl[rst_stop_pkg::debug_rst_bit];
    assign internal_event = power_on_event || watchdog_timeout || brownout_warning
                            || debug_req || (state == rst_stop_pkg::recv_s && hold_done);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_cnt  <= rst_stop_pkg::sys_rst_cycles;
            in_reset <= 1'b1;
        end else if (internal_event) begin
            rst_cnt  <= rst_stop_pkg::sys_rst_cycles;
            in_reset <= 1'b1;
        end else if (rst_cnt != 16'h0000) begin
            rst_cnt <= rst_cnt - 16'h0001;
        end else begin
            in_reset <= pin_reset || (pin_low && in_reset);
        end
    end
    assign system_reset = in_reset || pin_reset;
    assign debug_keep = 1'b1;
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe  = (in_reset && rst_cnt != 16'h0000) || ctrl[rst_stop_pkg::pin_drive_bit];

    assign vector_fetch_addr = system_reset ? rst_stop_pkg::reset_vector_hi
                                            : rst_stop_pkg::reset_vector_lo;

    ////////////////////////////////////////////////////////////////////////
    // cause flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cause <= 5'h02;
        end else begin
            if (do_write && aw_addr == rst_stop_pkg::cause_addr && w_strb[0]) begin
                cause <= cause & ~w_data[4:0];
            end
            if (pin_reset) begin
                cause[rst_stop_pkg::cause_pin] <= 1'b1;
            end
            if (power_on_event || debug_req) begin
                cause[rst_stop_pkg::cause_por] <= 1'b1;
            end
            if (watchdog_timeout) begin
                cause[rst_stop_pkg::cause_wdog] <= 1'b1;
            end
            if (brownout_warning) begin
                cause[rst_stop_pkg::cause_bo] <= 1'b1;
            end
            if (state == rst_stop_pkg::recv_s && hold_done) begin
                cause[rst_stop_pkg::cause_stop] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power state machine
    assign hold_done = prec_osc_tick && (ctrl[rst_stop_pkg::xtal_en_bit]
        ? hold_cnt >= 13'(stop_hold_long - 1)
        : hold_cnt >= 13'(rst_stop_pkg::stop_hold_prec - 1));
    always_ff @(posedge aclk) begin
        if (!aresetn || system_reset) begin
            state    <= rst_stop_pkg::run_s;
            hold_cnt <= 13'h0000;
        end else begin
            unique case (state)
                rst_stop_pkg::run_s: begin
                    if (ctrl[rst_stop_pkg::stop_cmd_bit]) begin
                        state <= rst_stop_pkg::stop_s;
                    end else if (ctrl[rst_stop_pkg::halt_cmd_bit]) begin
                        state <= rst_stop_pkg::halt_s;
                    end
                end
                rst_stop_pkg::halt_s: begin
                    if (!ctrl[rst_stop_pkg::halt_cmd_bit]) begin
                        state <= rst_stop_pkg::run_s;
                    end
                end
                rst_stop_pkg::stop_s: begin
                    if (stop_exit_request) begin
                        state    <= rst_stop_pkg::recv_s;
                        hold_cnt <= 13'h0000;
                    end
                end
                rst_stop_pkg::recv_s: begin
                    if (prec_osc_tick) begin
                        hold_cnt <= hold_cnt + 13'h0001;
                    end
                end
            endcase
        end
    end
    assign stop_recovery_reset = state == rst_stop_pkg::recv_s;
    assign cpu_reset    = system_reset || stop_recovery_reset;
    assign sys_clock_en = state != rst_stop_pkg::stop_s;
    assign cpu_clock_en = state == rst_stop_pkg::run_s;
    assign prec_osc_enable = state != rst_stop_pkg::stop_s;
    assign xtal_enable  = state != rst_stop_pkg::stop_s && state != rst_stop_pkg::recv_s
                          && ctrl[rst_stop_pkg::xtal_en_bit];
    assign xtal_pins_to_port = !xtal_enable;
    assign osc_select   = ctrl[rst_stop_pkg::osc_sel_lo +: 2];
    assign periph_enable = (state == rst_stop_pkg::stop_s) ? 8'h00
                           : power[rst_stop_pkg::pwr_periph_lo +: 8];
    assign watchdog_osc_run = power[rst_stop_pkg::pwr_wdog_osc];
    assign watchdog_run     = power[rst_stop_pkg::pwr_wdog];
    assign brownout_run = state != rst_stop_pkg::stop_s || brownout_stop_option;
    assign amp_run      = power[rst_stop_pkg::pwr_amp];

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path.
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h00000000;
            w_strb  <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= rst_stop_pkg::resp_okay;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr == rst_stop_pkg::ctrl_addr
                              || aw_addr == rst_stop_pkg::cause_addr
                              || aw_addr == rst_stop_pkg::power_addr)
                              ? rst_stop_pkg::resp_okay : rst_stop_pkg::resp_slverr;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Control register; stop clears its command bit and recovery rewrites the oscillator select field.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= 8'h00;
        end else begin
            if (do_write && aw_addr == rst_stop_pkg::ctrl_addr && w_strb[0]) begin
                ctrl <= w_data[7:0];
            end
            if (state == rst_stop_pkg::stop_s) begin
                ctrl[rst_stop_pkg::stop_cmd_bit] <= 1'b0;
            end
            if (system_reset) begin
                ctrl[rst_stop_pkg::debug_rst_bit] <= 1'b0;
                ctrl[rst_stop_pkg::halt_cmd_bit]  <= 1'b0;
            end
            if (stop_recovery_reset) begin
                ctrl[rst_stop_pkg::osc_sel_lo +: 2] <= rst_stop_pkg::osc_precision;
                ctrl[rst_stop_pkg::halt_cmd_bit]    <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power <= {rst_stop_pkg::periph_reset, 3'h3};
        end else if (do_write && aw_addr == rst_stop_pkg::power_addr) begin
            if (w_strb[0]) begin
                power[7:0] <= w_data[7:0];
            end
            if (w_strb[1]) begin
                power[10:8] <= w_data[10:8];
            end
        end
    end

    // AXI4-Lite read path.
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= rst_stop_pkg::resp_okay;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= rst_stop_pkg::resp_okay;
            unique case (s_axi_araddr)
                rst_stop_pkg::ctrl_addr:  s_axi_rdata <= {24'h000000, ctrl};
                rst_stop_pkg::cause_addr: s_axi_rdata <= {27'h0000000, cause};
                rst_stop_pkg::power_addr: s_axi_rdata <= {21'h000000, power};
                rst_stop_pkg::state_addr: s_axi_rdata <= {30'h00000000, state};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= rst_stop_pkg::resp_slverr;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // indicator during reset
    pin_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(system_reset) && !pin_low |-> reset_pin_oe)
        else $error("reset pin not driven during reset");
    debug_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        debug_req |-> ##[1:2] !debug_req)
        else $error("debug request did not clear");
    debug_por_a: assert property (@(posedge aclk) disable iff (!aresetn)
        debug_req |=> cause[rst_stop_pkg::cause_por])
        else $error("power-on flag not set after debug reset");
    pin_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        pin_reset |=> cause[rst_stop_pkg::cause_pin])
        else $error("external flag not set");
    stop_clock_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state == rst_stop_pkg::stop_s |-> !sys_clock_en && !cpu_clock_en && !prec_osc_enable)
        else $error("clock running in stop");
    halt_periph_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state == rst_stop_pkg::halt_s |-> sys_clock_en && !cpu_clock_en)
        else $error("halt state clocks wrong");
    event_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
        internal_event |=> reset_pin_oe [*8])
        else $error("reset pin released too early");
    recv_osc_a: assert property (@(posedge aclk) disable iff (!aresetn)
        stop_recovery_reset |=> osc_select == rst_stop_pkg::osc_precision)
        else $error("precision oscillator not selected");
endmodule
`default_nettype wire

// ### logic/rst_stop_pkg.sv
// Constants shared by the reset and stop-mode control block.
// Function
// - Reset from pin, POR, watchdog, stop-exit, brownout.
// - Four-cycle low pin pulse always resets; code ignores the pin while it drives it and for four clocks after.
// - Stay reset while pin low; exit after release.
// - Pin reset sets external flag.
// - Pin drives open-drain low during reset.
// - Internal reset holds pin low for delay.
// - Debug request resets chip except debugger.
// - Debug request bit self-clears during reset.
// - Debug reset sets power-on flag.
// - Stop recovery holds CPU 66 or 5000.
// - Stop recovery changes only watchdog, oscillator control; code ends it with a full system reset.
// - Stop recovery enables and selects precision oscillator.
// - Fetch reset vector from 0002H and 0003H.
// - Stop powers down all but four blocks.
// - Stop halts oscillators, clock, CPU, counter.
// - Stop returns crystal pins to port control.
// - Watchdog and its oscillator may run.
// - Brownout and amplifier stay per enables.
// - Halt powers down CPU only.
// - Stop exits through recovery sequence or system reset.
package rst_stop_pkg;
    // Register byte addresses.
    localparam logic [7:0] ctrl_addr   = 8'h00;
    localparam logic [7:0] cause_addr  = 8'h04;
    localparam logic [7:0] power_addr  = 8'h08;
    localparam logic [7:0] state_addr  = 8'h0c;
    // Control register fields.
    localparam int debug_rst_bit = 0;
    localparam int stop_cmd_bit  = 1;
    localparam int halt_cmd_bit  = 2;
    localparam int xtal_en_bit   = 3;
    localparam int pin_drive_bit = 4;
    localparam int osc_sel_lo    = 5;
    // Cause register fields.
    localparam int cause_pin  = 0;
    localparam int cause_por  = 1;
    localparam int cause_wdog = 2;
    localparam int cause_bo   = 3;
    localparam int cause_stop = 4;
    // Power control fields.
    localparam int pwr_wdog_osc = 0;
    localparam int pwr_wdog     = 1;
    localparam int pwr_amp     = 2;
    localparam int pwr_periph_lo = 3;
    localparam logic [7:0] periph_reset = 8'hff;
    // Oscillator select codes.
    localparam logic [1:0] osc_precision = 2'h0;
    // Pin filter length in system clocks.
    localparam logic [2:0] pin_filter = 3'h4;
    // Reset delay in system clocks for internal sources.
    localparam logic [15:0] sys_rst_cycles = 16'h0040;
    // Stop recovery holds, in precision oscillator cycles.
    localparam int stop_hold_prec = 66;
    localparam int stop_hold_xtal = 5000;
    localparam logic [15:0] reset_vector_hi = 16'h0002;
    localparam logic [15:0] reset_vector_lo = 16'h0003;
    localparam logic [1:0] resp_okay   = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
    typedef enum logic [1:0] {
        run_s  = 2'b00,
        halt_s = 2'b01,
        stop_s = 2'b10,
        recv_s = 2'b11
    } power_state_t;
endpackage

// ### tb/reset_line_board.sv
// Board model of the parts sharing the open-drain reset line.
`timescale 1ns/1ps
`default_nettype none
module reset_line_board (
    // Clock.
    input  wire logic aclk,
    // Device side of the line.
    input  wire logic dut_oe,
    input  wire logic dut_out,
    // Resolved line level.
    output logic      pin_level
);
    logic press_low = 1'b0;
    // open-drain line
    // The pull-up wins unless some party pulls the line low.
    assign pin_level = ((dut_oe && !dut_out) || press_low) ? 1'b0 : 1'b1;
    task automatic press(input int n);
        @(posedge aclk);
        press_low <= 1'b1;
        repeat (n) @(posedge aclk);
        press_low <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### tb/test_reset_and_stop_mode_control.sv
// Self-checking bench of the reset and stop-mode control block.
`timescale 1ns/1ps
`default_nettype none
module test_reset_and_stop_mode_control;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        wd_to, bo_warn, por_ev, bo_opt, stop_req, osc_tick, pin_level;
    logic        awready, wready, bvalid, arready, rvalid, sys_rst, cpu_rst, pin_out, pin_oe;
    logic        dbg_keep, cpu_en, sys_en, osc_en, xtal_en, xp, wosc, wrun, bo_run, amp_on, srr;
    logic [1:0]  bresp, rresp, osc_sel, tick_div, rsp;
    logic [7:0]  awaddr, araddr, periph;
    logic [15:0] vec;
    logic [31:0] wdata, rdata, rd;
    int          n_fail, cmp_count, cycles;

    rst_stop_ctrl #(.stop_hold_long(100)) dut_u (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .reset_pin_in(pin_level), .reset_pin_out(pin_out), .reset_pin_oe(pin_oe),
        .power_on_event(por_ev), .watchdog_timeout(wd_to), .brownout_warning(bo_warn),
        .stop_exit_request(stop_req), .prec_osc_tick(osc_tick), .brownout_stop_option(bo_opt),
        .system_reset(sys_rst), .debug_keep(dbg_keep), .cpu_reset(cpu_rst),
        .vector_fetch_addr(vec), .cpu_clock_en(cpu_en), .sys_clock_en(sys_en),
        .prec_osc_enable(osc_en), .xtal_enable(xtal_en), .osc_select(osc_sel),
        .xtal_pins_to_port(xp), .periph_enable(periph), .watchdog_osc_run(wosc),
        .watchdog_run(wrun), .brownout_run(bo_run), .amp_run(amp_on),
        .stop_recovery_reset(srr)
    );
    reset_line_board board_u (.aclk(aclk), .dut_oe(pin_oe), .dut_out(pin_out), .pin_level(pin_level));

    always #20 aclk = ~aclk;
    // One precision oscillator tick every third system clock.
    always @(posedge aclk) begin
        tick_div <= (tick_div == 2'h2) ? 2'h0 : tick_div + 2'h1;
        osc_tick <= (tick_div == 2'h2);
    end
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 30000) begin
            n_fail++;
            stop_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        rsp = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask
    task automatic wait_sys(input logic lvl, input int max);
        for (int i = 0; i < max; i++) begin
            if (sys_rst === lvl) return;
            @(posedge aclk);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_defaults;
        @(posedge aclk);
        chk({sys_rst, pin_level, cpu_rst}, 3'b101);
        chk(vec, 16'h0002);
        wait_sys(1'b0, 100);
        chk(vec, 16'h0003);
        axi_read(rst_stop_pkg::cause_addr);
        chk(rd, 32'h0000_0002);
        axi_read(8'h10);
        chk(rsp, rst_stop_pkg::resp_slverr);
        chk(rd, 32'h0);
        axi_write(8'h14, 32'h0);
        chk(rsp, rst_stop_pkg::resp_slverr);
        axi_write(rst_stop_pkg::ctrl_addr, 32'h0000_0004);
        repeat (2) @(posedge aclk);
        chk({cpu_en, sys_en, periph}, {2'b01, 8'hff});
        axi_write(rst_stop_pkg::ctrl_addr, 32'h0);
        $display("defaults and halt done");
    endtask
    task automatic test_pin;
        axi_write(rst_stop_pkg::cause_addr, 32'h0000_001f);
        board_u.press(4);
        wait_sys(1'b1, 20);
        chk(sys_rst, 1'b1);
        wait_sys(1'b0, 200);
        axi_read(rst_stop_pkg::cause_addr);
        chk(rd, 32'h0000_0001);
        fork
            board_u.press(150);
            begin
                repeat (140) @(posedge aclk);
                chk(sys_rst, 1'b1);
            end
        join
        wait_sys(1'b0, 200);
        chk(sys_rst, 1'b0);
        $display("reset pin done");
    endtask
    task automatic test_sources;
        for (int i = 0; i < 3; i++) begin
            axi_write(rst_stop_pkg::cause_addr, 32'h0000_001f);
            @(posedge aclk);
            if (i == 0) wd_to <= 1'b1;
            else if (i == 1) bo_warn <= 1'b1;
            else por_ev <= 1'b1;
            @(posedge aclk);
            wd_to <= 1'b0;
            bo_warn <= 1'b0;
            por_ev <= 1'b0;
            wait_sys(1'b1, 10);
            repeat (2) @(posedge aclk);
            chk({sys_rst, pin_level}, 2'b10);
            wait_sys(1'b0, 200);
            axi_read(rst_stop_pkg::cause_addr);
            chk(rd, (i == 2) ? 32'h2 : (32'h1 << (2 + i)));
        end
        $display("internal sources done");
    endtask
    task automatic test_debug;
        axi_write(rst_stop_pkg::cause_addr, 32'h0000_001f);
        axi_write(rst_stop_pkg::ctrl_addr, 32'h0000_0001);
        wait_sys(1'b1, 10);
        chk({sys_rst, dbg_keep}, 2'b11);
        wait_sys(1'b0, 200);
        axi_read(rst_stop_pkg::ctrl_addr);
        chk(rd[0], 1'b0);
        axi_read(rst_stop_pkg::cause_addr);
        chk(rd, 32'h0000_0002);
        $display("debug reset done");
    endtask
    task automatic test_stop;
        int n;
        logic seen;
        for (int i = 0; i < 2; i++) begin
            axi_write(rst_stop_pkg::power_addr, 32'h0000_0007);
            bo_opt <= (i == 0);
            axi_write(rst_stop_pkg::ctrl_addr, 32'h22 | (i << 3));
            repeat (20) @(posedge aclk);
            chk({sys_en, cpu_en, osc_en, xtal_en, xp}, 5'h01);
            chk({wosc, wrun, amp_on, bo_run}, {3'h7, bo_opt});
            chk(periph, 8'h00);
            @(posedge aclk);
            stop_req <= 1'b1;
            @(posedge aclk);
            stop_req <= 1'b0;
            n = 0;
            seen = 1'b0;
            for (int k = 0; k < 3000; k++) begin
                @(posedge aclk);
                if (srr === 1'b1) begin
                    seen = 1'b1;
                    if (osc_tick === 1'b1) n++;
                end else if (seen) break;
            end
            chk(n >= (i ? 100 : 66) && n <= (i ? 101 : 67), 1'b1);
            wait_sys(1'b0, 300);
            chk({osc_en, osc_sel}, {1'b1, rst_stop_pkg::osc_precision});
            axi_read(rst_stop_pkg::cause_addr);
            chk(rd[4], 1'b1);
            axi_read(rst_stop_pkg::power_addr);
            chk(rd, 32'h0000_0007);
        end
        $display("stop recovery done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
        {wd_to, bo_warn, por_ev, bo_opt, stop_req, osc_tick, tick_div} = 8'h0;
        {awaddr, araddr, wdata} = 48'h0;
        n_fail = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        test_defaults();
        test_pin();
        test_sources();
        test_debug();
        test_stop();
        stop_test();
    end
endmodule
`default_nettype wire
